// *** src/palsf_defines.svh ***
// Register offsets, field positions and the stored alarm bit mask for the pack alarm latch.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef PALSF_DEFINES_SVH
`define PALSF_DEFINES_SVH

// Byte offsets on the APB register bus.
`define PALSF_OFF_PACK_STATUS 12'h000
`define PALSF_OFF_ALARM_STATUS 12'h004
`define PALSF_OFF_ALARM_ENABLE 12'h008
`define PALSF_OFF_CONTROL 12'h00C
`define PALSF_OFF_RAW_ALARM 12'h010

// Pack status word fields.
`define PALSF_PS_CFG_EDIT 0
`define PALSF_PS_PRECHARGE 1
`define PALSF_PS_SLEEP_OK 2
`define PALSF_PS_FULL_RESET 3
`define PALSF_PS_WDOG_CAUSE 4
`define PALSF_PS_OPEN_WIRE 5

// Alarm word fields.
`define PALSF_AL_WAKE 0
`define PALSF_AL_SCAN 1
`define PALSF_AL_BALANCE 2
`define PALSF_AL_BLOW 3
`define PALSF_AL_STACK_LOW 4
`define PALSF_AL_DISCHARGE_OFF 5
`define PALSF_AL_CHARGE_OFF 6
`define PALSF_AL_LOOP 7
`define PALSF_AL_RSVD 8
`define PALSF_AL_INIT_DONE 9
`define PALSF_AL_INIT_BEGUN 10
`define PALSF_AL_PERMFAIL_ALERT 11
`define PALSF_AL_SF_ALERT 12
`define PALSF_AL_PERM_FAIL 13
`define PALSF_AL_SAFETY_A 14
`define PALSF_AL_SAFETY_BC 15

// Control register fields (write side).
`define PALSF_CT_SLEEP_SET 0
`define PALSF_CT_SLEEP_CLR 1
`define PALSF_CT_CFG_ENTER 2
`define PALSF_CT_CFG_EXIT 3

// Reserved alarm bit is never stored.
`define PALSF_ALARM_VALID 16'hFEFF

`endif

// *** src/palsf_pkg.sv ***
// Types shared by the pack alarm latch design.
// Assumes nothing beyond a SystemVerilog compiler.
package palsf_pkg;

	// Configuration-edit command sequencer states, one-hot.
	typedef enum logic [2:0] {
		CFG_IDLE = 3'h1,
		CFG_PROC = 3'h2,
		CFG_EDIT = 3'h4
	} palsf_cfg_e;

endpackage

// *** src/palsf_alarm_latch.sv ***
// Pack status flags and latched alarm word behind an APB slave.
// Assumes raw events arrive from logic on pclk; the alert pin is a plain output.
`timescale 1ns/10ps
`include "palsf_defines.svh"

// Notes on behaviour
// - Bit 5 high only during open-wire check.
// - Bit 4 shows watchdog caused last reset.
// - Bit 3 set on reset, cleared leaving edit.
// - Bit 2 sleep permission, default, host set/clear.
// - Bit 1 shows precharge mode active.
// - Bit 0 set after edit command fully processed.
// - Latched alarm bits drive the alert pin.
// - Write one clears alarm latch bit.
// - Alarm 15 from safety words B/C.
// - Alarm 14 from safety word A.
// - Alarm 13 on enabled permanent fail.
// - Alarm 12 on masked safety alert.
// - Alarm 11 on masked permanent-fail alert.
// - Alarm 10 init begun, 9 init done.
// - Alarm 7 each full loop done.
// - Alarm 6/5 while charge/discharge switches off.
// - Alarm 4 when stack below shutdown.
// - Alarm 3 while blow pin driven.
// - Alarm 2 while balancing active.
// - Alarm 1 each single scan done.
// - Alarm 0 on wake from sleep.
// - Enable mask gates latching, host rewritable.
module palsf_alarm_latch #(
	parameter logic [15:0] DEFAULT_ALARM_MASK = 16'hFEFF, // Configured default enable mask.
	parameter logic DEFAULT_SLEEP_OK = 1'b1, // Configured default sleep permission.
	parameter int CFG_PROC_CYCLES = 4 // Cycles to process the enter-edit command.
) (
	// APB slave.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Device state inputs, same clock domain.
	input wire logic open_wire_check_active,
	input wire logic watchdog_reset_cause,
	input wire logic precharge_active,
	// Raw alarm events, same clock domain.
	input wire logic [15:0] safety_b_word,
	input wire logic [15:0] safety_c_word,
	input wire logic [15:0] safety_a_word,
	input wire logic permanent_fail_alarm,
	input wire logic masked_safety_alert,
	input wire logic masked_permfail_alert,
	input wire logic init_begun,
	input wire logic init_done,
	input wire logic full_loop_done,
	input wire logic charge_switch_off,
	input wire logic discharge_switch_off,
	input wire logic stack_below_shutdown,
	input wire logic blow_pin_driven,
	input wire logic balancing_active,
	input wire logic single_scan_done,
	input wire logic sleep_wake,
	// Outputs toward the device and host.
	output logic alert,
	output logic sleep_allowed,
	output logic config_edit_active
);

	// Bus qualifiers: every access completes in its first access cycle.
	// A read is decoded in the setup cycle, so prdata is registered before the access edge samples it.
	// A write commits only in the access cycle, so it takes effect exactly once per transfer.
	logic bus_wr; // Write commit strobe.
	logic bus_rd; // Read capture strobe.
	assign bus_wr = psel && penable && pwrite;
	assign bus_rd = psel && !penable && !pwrite;
	assign pready = 1'b1;

	// Known offsets; anything else is answered with an error.
	logic addr_hit;
	always_comb begin
		case (paddr)
			`PALSF_OFF_PACK_STATUS, `PALSF_OFF_ALARM_STATUS, `PALSF_OFF_ALARM_ENABLE,
			`PALSF_OFF_CONTROL, `PALSF_OFF_RAW_ALARM: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !addr_hit;

	// Raw alarm vector assembled from the detectors.
	logic [15:0] raw_alarm;
	always_comb begin
		raw_alarm = 16'h0000;
		raw_alarm[`PALSF_AL_SAFETY_BC] = |{safety_b_word, safety_c_word};
		raw_alarm[`PALSF_AL_SAFETY_A] = |safety_a_word;
		raw_alarm[`PALSF_AL_PERM_FAIL] = permanent_fail_alarm;
		raw_alarm[`PALSF_AL_SF_ALERT] = masked_safety_alert;
		raw_alarm[`PALSF_AL_PERMFAIL_ALERT] = masked_permfail_alert;
		raw_alarm[`PALSF_AL_INIT_BEGUN] = init_begun;
		raw_alarm[`PALSF_AL_INIT_DONE] = init_done;
		raw_alarm[`PALSF_AL_LOOP] = full_loop_done;
		raw_alarm[`PALSF_AL_CHARGE_OFF] = charge_switch_off;
		raw_alarm[`PALSF_AL_DISCHARGE_OFF] = discharge_switch_off;
		raw_alarm[`PALSF_AL_STACK_LOW] = stack_below_shutdown;
		raw_alarm[`PALSF_AL_BLOW] = blow_pin_driven;
		raw_alarm[`PALSF_AL_BALANCE] = balancing_active;
		raw_alarm[`PALSF_AL_SCAN] = single_scan_done;
		raw_alarm[`PALSF_AL_WAKE] = sleep_wake;
	end

	// Alarm latch, enable mask and register state.
	logic [15:0] alarm_latch;
	logic [15:0] next_alarm_latch;
	logic [15:0] alarm_enable;
	logic [15:0] next_alarm_enable;
	logic [15:0] clear_bits;

	// Set wins over clear so an event in the clearing cycle is kept.
	// A level source such as a switch-off flag therefore cannot be cleared while it persists.
	always_comb begin
		clear_bits = (bus_wr && paddr == `PALSF_OFF_ALARM_STATUS) ? pwdata[15:0] : 16'h0000;
		next_alarm_latch = ((alarm_latch & ~clear_bits) | (raw_alarm & alarm_enable))
			& `PALSF_ALARM_VALID;
		next_alarm_enable = alarm_enable;
		if (bus_wr && paddr == `PALSF_OFF_ALARM_ENABLE) begin
			next_alarm_enable = pwdata[15:0] & `PALSF_ALARM_VALID;
		end
	end

	// Registers for the alarm group.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_latch <= 16'h0000;
			alarm_enable <= DEFAULT_ALARM_MASK & `PALSF_ALARM_VALID;
		end else begin
			alarm_latch <= next_alarm_latch;
			alarm_enable <= next_alarm_enable;
		end
	end

	// Alert is a level held while any latch bit stands.
	// It is an OR of flops only, so bus decoding cannot make it glitch.
	assign alert = |alarm_latch;

	// Configuration-edit sequencer, sleep permission and full-reset flag.
	palsf_pkg::palsf_cfg_e cfg_state;
	palsf_pkg::palsf_cfg_e next_cfg_state;
	logic [7:0] proc_cnt;
	logic [7:0] next_proc_cnt;
	logic sleep_ok;
	logic next_sleep_ok;
	logic full_reset_flag;
	logic next_full_reset_flag;
	logic ctl_wr;
	assign ctl_wr = bus_wr && paddr == `PALSF_OFF_CONTROL;

	// The enter command is taken, then processed for a fixed time before the flag rises.
	always_comb begin
		next_cfg_state = cfg_state;
		next_proc_cnt = proc_cnt;
		next_sleep_ok = sleep_ok;
		next_full_reset_flag = full_reset_flag;
		case (cfg_state)
			palsf_pkg::CFG_IDLE: begin
				if (ctl_wr && pwdata[`PALSF_CT_CFG_ENTER]) begin
					next_cfg_state = palsf_pkg::CFG_PROC;
					// The zero-count cycle counts as the last processing cycle, hence one less.
					next_proc_cnt = 8'(CFG_PROC_CYCLES - 1);
				end
			end
			palsf_pkg::CFG_PROC: begin
				if (proc_cnt == 8'h00) begin
					next_cfg_state = palsf_pkg::CFG_EDIT;
				end else begin
					next_proc_cnt = proc_cnt - 8'h01;
				end
			end
			palsf_pkg::CFG_EDIT: begin
				if (ctl_wr && pwdata[`PALSF_CT_CFG_EXIT]) begin
					next_cfg_state = palsf_pkg::CFG_IDLE;
					next_full_reset_flag = 1'b0;
				end
			end
			default: begin
				next_cfg_state = palsf_pkg::CFG_IDLE;
			end
		endcase
		// Set beats clear when both are written together, keeping sleep allowed.
		if (ctl_wr && pwdata[`PALSF_CT_SLEEP_CLR]) begin
			next_sleep_ok = 1'b0;
		end
		if (ctl_wr && pwdata[`PALSF_CT_SLEEP_SET]) begin
			next_sleep_ok = 1'b1;
		end
	end

	// Registers for the status group; full-reset flag comes up set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_state <= palsf_pkg::CFG_IDLE;
			proc_cnt <= 8'h00;
			sleep_ok <= DEFAULT_SLEEP_OK;
			full_reset_flag <= 1'b1;
		end else begin
			cfg_state <= next_cfg_state;
			proc_cnt <= next_proc_cnt;
			sleep_ok <= next_sleep_ok;
			full_reset_flag <= next_full_reset_flag;
		end
	end

	assign config_edit_active = (cfg_state == palsf_pkg::CFG_EDIT);
	assign sleep_allowed = sleep_ok;

	// Pack status word assembled live.
	// Bits 15 to 6 belong to other blocks and read as zero here.
	logic [15:0] pack_status;
	always_comb begin
		pack_status = 16'h0000;
		pack_status[`PALSF_PS_OPEN_WIRE] = open_wire_check_active;
		pack_status[`PALSF_PS_WDOG_CAUSE] = watchdog_reset_cause;
		pack_status[`PALSF_PS_FULL_RESET] = full_reset_flag;
		pack_status[`PALSF_PS_SLEEP_OK] = sleep_ok;
		pack_status[`PALSF_PS_PRECHARGE] = precharge_active;
		pack_status[`PALSF_PS_CFG_EDIT] = config_edit_active;
	end

	// Read data is captured in the setup cycle and held through the access cycle.
	// Holding it until the next read costs a 32-bit register but keeps a late sample valid.
	logic [31:0] next_prdata;
	always_comb begin
		next_prdata = prdata;
		if (bus_rd) begin
			case (paddr)
				`PALSF_OFF_PACK_STATUS: next_prdata = {16'h0000, pack_status};
				`PALSF_OFF_ALARM_STATUS: next_prdata = {16'h0000, alarm_latch};
				`PALSF_OFF_ALARM_ENABLE: next_prdata = {16'h0000, alarm_enable};
				`PALSF_OFF_RAW_ALARM: next_prdata = {16'h0000, raw_alarm & `PALSF_ALARM_VALID};
				default: next_prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= next_prdata;
		end
	end

	// Checks on the alarm group.
	// Alarm bit 15, when enabled and raised, must be set one edge later.
	alarm_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
		(raw_alarm[15] && alarm_enable[15]) |=> alarm_latch[15])
		else $error("enabled alarm did not latch");

	// A write of one clears bit 1 when its source is quiet.
	w1c_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_wr && paddr == `PALSF_OFF_ALARM_STATUS && pwdata[1] && !(raw_alarm[1] && alarm_enable[1]))
		|=> !alarm_latch[1])
		else $error("write one did not clear latch");

	// A zero write leaves latches untouched.
	zero_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_wr && paddr == `PALSF_OFF_ALARM_STATUS && pwdata[15:0] == 16'h0000)
		|=> alarm_latch == ($past(alarm_latch) | $past(raw_alarm & alarm_enable & `PALSF_ALARM_VALID)))
		else $error("zero write changed latch");

	// Alert rises the edge after any enabled source fires.
	alert_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|(raw_alarm & alarm_enable)) |=> alert)
		else $error("alert did not follow an enabled alarm");

	// With no clearing write, a raised alert stays up.
	alert_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(alert && !(bus_wr && paddr == `PALSF_OFF_ALARM_STATUS)) |=> alert)
		else $error("alert dropped without a clear");

	// An enable write lands at the access edge with bit 8 forced low.
	enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_wr && paddr == `PALSF_OFF_ALARM_ENABLE)
		|=> alarm_enable == ($past(pwdata[15:0]) & `PALSF_ALARM_VALID))
		else $error("enable write not stored");

	// Reserved bit never sets.
	rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		!alarm_latch[8] && !alarm_enable[8])
		else $error("reserved bit set");

	// Checks on the status group.
	// Edit flag rises only after the processing delay.
	cfg_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_state == palsf_pkg::CFG_IDLE && ctl_wr && pwdata[`PALSF_CT_CFG_ENTER])
		|=> !config_edit_active [*4] ##1 config_edit_active)
		else $error("edit mode timing wrong");

	// Leaving edit clears the full-reset flag.
	por_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(config_edit_active && ctl_wr && pwdata[`PALSF_CT_CFG_EXIT]) |=> !full_reset_flag && !config_edit_active)
		else $error("full reset flag not cleared");

	// The full-reset flag only falls on leaving edit mode.
	flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(full_reset_flag && !(config_edit_active && ctl_wr && pwdata[`PALSF_CT_CFG_EXIT]))
		|=> full_reset_flag)
		else $error("full reset flag fell early");

	// Once cleared, the flag comes back only through a reset.
	flag_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		!full_reset_flag |=> !full_reset_flag)
		else $error("full reset flag rose without reset");

	// Sleep commands take effect at the next edge.
	sleep_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl_wr && pwdata[`PALSF_CT_SLEEP_CLR] && !pwdata[`PALSF_CT_SLEEP_SET]) |=> !sleep_allowed)
		else $error("sleep clear ignored");

	// A set command wins even when a clear comes with it.
	sleep_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl_wr && pwdata[`PALSF_CT_SLEEP_SET]) |=> sleep_allowed)
		else $error("sleep set ignored");

	// Without a command, sleep permission keeps its value.
	sleep_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(ctl_wr && (pwdata[`PALSF_CT_SLEEP_SET] || pwdata[`PALSF_CT_SLEEP_CLR]))
		|=> $stable(sleep_allowed))
		else $error("sleep permission changed unasked");

	// Edit mode is only reached through the processing state.
	edit_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(config_edit_active) |-> $past(cfg_state) == palsf_pkg::CFG_PROC)
		else $error("edit mode entered without processing");

	// Edit mode holds until an exit command is written.
	edit_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(config_edit_active && !(ctl_wr && pwdata[`PALSF_CT_CFG_EXIT])) |=> config_edit_active)
		else $error("edit mode left without exit");

	// A second enter during processing does not disturb the count.
	busy_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_state == palsf_pkg::CFG_PROC && proc_cnt != 8'h00)
		|=> cfg_state == palsf_pkg::CFG_PROC && proc_cnt == $past(proc_cnt) - 8'h01)
		else $error("processing count disturbed");

	// A latch read returns the word as it stood in the setup cycle.
	read_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_rd && paddr == `PALSF_OFF_ALARM_STATUS)
		|=> prdata == {16'h0000, $past(alarm_latch)})
		else $error("latch read back wrong");

	// Open-wire bit mirrors the check.
	open_wire_a: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_rd && paddr == `PALSF_OFF_PACK_STATUS)
		|=> prdata[5:4] == $past({open_wire_check_active, watchdog_reset_cause})
		&& prdata[1] == $past(precharge_active))
		else $error("status bits wrong");

	// Each stored bit sets only from its own enabled source and clears only by a written one.
	for (genvar b = 0; b < 16; b++) begin : g_bit_chk
		// A quiet bit stays quiet unless its enabled source fires.
		no_spurious_a: assert property (@(posedge pclk) disable iff (!presetn)
			(!alarm_latch[b] && !(raw_alarm[b] && alarm_enable[b])) |=> !alarm_latch[b])
			else $error("alarm bit set with no source");
		// A set bit stays set until a one is written to it.
		latch_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
			(alarm_latch[b] && !(bus_wr && paddr == `PALSF_OFF_ALARM_STATUS && pwdata[b])) |=> alarm_latch[b])
			else $error("alarm bit dropped without a clear");
	end

endmodule // palsf_alarm_latch

// *** testbench/palsf_host.sv ***
// Host controller model: an APB master that reads status and services alarms.
// Assumes one pclk domain and a slave that raises pready when a transfer ends.
`timescale 1ns/10ps
module palsf_host (
	// Clock.
	input wire logic pclk,
	// Requests toward the slave.
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	// Answers from the slave.
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// The bus is idle at time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end

	// One transfer; the request holds until pready is seen high at an edge.
	// The host clears alarms with ones and steers sleep and edit mode by writes.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data shows a changed value so nothing stale is reused.
		pwdata <= ~d;
	endtask
endmodule // palsf_host

// *** testbench/tb_top.sv ***
// Self-checking bench for the pack status flags and latched alarm word.
// Assumes the host model drives APB; the bench drives all raw event inputs.
`timescale 1ns/10ps
`include "palsf_defines.svh"
module tb_top;
	localparam int PROC = 4; // Edit command processing cycles.
	logic pclk;
	logic presetn;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic ow, wd, pc; // Device state levels.
	logic [15:0] sa, sb, sc; // Safety words.
	logic [12:0] ev; // Single-bit alarm events.
	logic alert, sleep_allowed, config_edit_active;
	int failures = 0;
	int n_checks = 0;
	int n;

	// A 200 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	palsf_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	palsf_alarm_latch #(.CFG_PROC_CYCLES(PROC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .open_wire_check_active(ow), .watchdog_reset_cause(wd),
		.precharge_active(pc), .safety_b_word(sb), .safety_c_word(sc), .safety_a_word(sa),
		.permanent_fail_alarm(ev[12]), .masked_safety_alert(ev[11]), .masked_permfail_alert(ev[10]),
		.init_begun(ev[9]), .init_done(ev[8]), .full_loop_done(ev[7]), .charge_switch_off(ev[6]),
		.discharge_switch_off(ev[5]), .stack_below_shutdown(ev[4]), .blow_pin_driven(ev[3]),
		.balancing_active(ev[2]), .single_scan_done(ev[1]), .sleep_wake(ev[0]), .alert(alert),
		.sleep_allowed(sleep_allowed), .config_edit_active(config_edit_active));

	// Compares and counts; a mismatch is reported at once.
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		logic e;
		host.xfer(1'b0, a, 32'h00000000, d, e);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		host.xfer(1'b1, a, d, x, e);
	endtask

	// Reset is held for twelve cycles and released just after an edge.
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// Drives the raw source of one alarm bit; bit 8 has none.
	task automatic src(input int i, input logic v);
		@(posedge pclk);
		if (i == 15) sc <= v ? 16'h8000 : 16'h0000;
		else if (i == 14) sa <= v ? 16'h0001 : 16'h0000;
		else if (i < 8) ev[i] <= v;
		else if (i > 8) ev[i-1] <= v;
	endtask

	// Reset values and the unmapped address.
	task automatic t_reset();
		logic e;
		rd(`PALSF_OFF_PACK_STATUS, q);
		chk("status", q, 32'h0000000C);
		rd(`PALSF_OFF_ALARM_STATUS, q);
		chk("latch", q, 32'h00000000);
		rd(`PALSF_OFF_ALARM_ENABLE, q);
		chk("enable", q, 32'h0000FEFF);
		chk("alert", alert, 1'b0);
		host.xfer(1'b0, 12'h040, 32'h00000000, q, e);
		chk("unmapped", {q[30:0], e}, 32'h00000001);
		$display("test reset done");
	endtask

	// Live status levels appear in bits 5, 4 and 1.
	task automatic t_status();
		@(posedge pclk);
		ow <= 1'b1;
		wd <= 1'b1;
		pc <= 1'b1;
		rd(`PALSF_OFF_PACK_STATUS, q);
		chk("status live", q, 32'h0000003E);
		@(posedge pclk);
		ow <= 1'b0;
		wd <= 1'b0;
		pc <= 1'b0;
		rd(`PALSF_OFF_PACK_STATUS, q);
		chk("status quiet", q, 32'h0000000C);
		$display("test status done");
	endtask

	// Every alarm source latches its bit, raises alert and clears by a written one.
	task automatic t_alarms();
		for (int i = 0; i < 16; i++) begin
			src(i, 1'b1);
			src(i, 1'b0);
			rd(`PALSF_OFF_ALARM_STATUS, q);
			chk("latched", q, (i == 8) ? 32'h0 : (32'h1 << i));
			chk("alert set", alert, i != 8);
			wr(`PALSF_OFF_ALARM_STATUS, 32'h0);
			rd(`PALSF_OFF_ALARM_STATUS, q);
			chk("zero kept", q, (i == 8) ? 32'h0 : (32'h1 << i));
			wr(`PALSF_OFF_ALARM_STATUS, 32'h1 << i);
			rd(`PALSF_OFF_ALARM_STATUS, q);
			chk("cleared", q, 32'h0);
			chk("alert clear", alert, 1'b0);
		end
		$display("test alarms done");
	endtask

	// Mask gating, bit 8 read back, and a held source that outlives a clear.
	task automatic t_mask();
		wr(`PALSF_OFF_ALARM_ENABLE, 32'h0000FFFD);
		rd(`PALSF_OFF_ALARM_ENABLE, q);
		chk("enable rb", q, 32'h0000FEFD);
		src(1, 1'b1);
		src(1, 1'b0);
		rd(`PALSF_OFF_ALARM_STATUS, q);
		chk("masked", q, 32'h0);
		@(posedge pclk);
		sb <= 16'h0008;
		wr(`PALSF_OFF_ALARM_STATUS, 32'h00008000);
		rd(`PALSF_OFF_ALARM_STATUS, q);
		chk("held", q, 32'h00008000);
		rd(`PALSF_OFF_RAW_ALARM, q);
		chk("raw held", q, 32'h00008000);
		@(posedge pclk);
		sb <= 16'h0000;
		wr(`PALSF_OFF_ALARM_STATUS, 32'h00008000);
		rd(`PALSF_OFF_ALARM_STATUS, q);
		chk("freed", q, 32'h0);
		wr(`PALSF_OFF_ALARM_ENABLE, 32'h0000FEFF);
		$display("test mask done");
	endtask

	// Sleep permission by control writes, then edit mode entry timing and exit.
	task automatic t_ctrl();
		wr(`PALSF_OFF_CONTROL, 32'h2);
		rd(`PALSF_OFF_PACK_STATUS, q);
		chk("sleep off", {q[2], sleep_allowed}, 2'b00);
		wr(`PALSF_OFF_CONTROL, 32'h3);
		rd(`PALSF_OFF_PACK_STATUS, q);
		chk("sleep on", {q[2], sleep_allowed}, 2'b11);
		wr(`PALSF_OFF_CONTROL, 32'h4);
		n = 0;
		while (config_edit_active !== 1'b1 && n < 20) begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk("edit delay", n, PROC);
		rd(`PALSF_OFF_PACK_STATUS, q);
		chk("in edit", q, 32'h0000000D);
		wr(`PALSF_OFF_CONTROL, 32'h8);
		rd(`PALSF_OFF_PACK_STATUS, q);
		chk("exit edit", q, 32'h00000004);
		do_reset();
		rd(`PALSF_OFF_PACK_STATUS, q);
		chk("full reset", q, 32'h0000000C);
		$display("test control done");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence; every input has a value at time zero.
	initial begin
		presetn = 1'b0;
		{ow, wd, pc} = 3'h0;
		{sa, sb, sc} = 48'h0;
		ev = 13'h0000;
		do_reset();
		t_reset();
		t_status();
		t_alarms();
		t_mask();
		t_ctrl();
		close_out();
	end

	// The tests take well under 2,000 cycles; the watchdog allows ten times that.
	initial begin
		#100000;
		failures++;
		close_out();
	end
endmodule // tb_top
